/* hdl/psta_pkg.sv */
// How it works
// R1: Low-word ops reach program bits 15:0 directly
// R2: Low-word ops also reach whole EEPROM words
// R3: High-word ops alone reach program bits 23:16
// R4: Core never issues high-word ops to EEPROM
// R5: Program words step by two address units
// R6: Low word read returns P15:0 on D15:0
// R7: Low byte read picks byte by select
// R8: High word read: P23:16 low, zero upper
// R9: High byte read: phantom byte reads zero
// R10: Reads and writes support byte and word
// R11: High write stores only bits 23:16
package psta_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int PROG_W   = 24;
    localparam int DATA_W   = 16;
    localparam int ADDR_W   = 16;
    localparam int BYTE_W   = 8;
    localparam int ROW_W    = 15;   // Word index bits (address without bit 0)
    localparam int PROG_WORDS = 8192;
    localparam int EE_WORDS   = 256;
    localparam int EE_IDX_W   = 8;
    localparam int PROG_IDX_W = 13;   // Program index bits, wraps above

    // ****************************************
    // Bit positions
    // ****************************************
    localparam int SEL_BIT     = 0;   // Byte select in the address
    localparam int ROW_LSB     = 1;   // Word index starts here
    localparam int LOW_LSB     = 0;   // Low program word
    localparam int LOW_MSB     = 15;
    localparam int HIGH_LSB    = 16;  // Upper program byte
    localparam int HIGH_MSB    = 23;
    localparam int BYTE_LO_LSB = 0;   // Byte lanes of a data word
    localparam int BYTE_HI_LSB = 8;

    // ****************************************
    // Fill values
    // ****************************************
    localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

    // Address decode: EEPROM window at the top of the lower half of table space
    localparam logic [ADDR_W-1:0] EE_BASE = 16'h7e00;
    localparam logic [ADDR_W-1:0] EE_MASK = 16'hfe00;

    // Operation codes
    typedef enum logic [1:0] {
        PSTA_OP_RD_LOW  = 2'b00,
        PSTA_OP_WR_LOW  = 2'b01,
        PSTA_OP_RD_HIGH = 2'b10,
        PSTA_OP_WR_HIGH = 2'b11
    } psta_op_t;

endpackage : psta_pkg

/* hdl/psta_table_access.sv */
`timescale 1ns/1ps
module psta_table_access (
    // Clock and reset
    input  wire logic                           clock_i,
    input  wire logic                           reset_n_i,
    // Request from core
    input  wire logic                           req_valid_i,
    input  wire psta_pkg::psta_op_t             req_op_i,
    input  wire logic                           req_byte_i,
    input  wire logic [psta_pkg::ADDR_W-1:0]    req_addr_i,
    input  wire logic [psta_pkg::DATA_W-1:0]    req_wdata_i,
    // Answer to core
    output logic                                rsp_valid_o,
    output logic [psta_pkg::DATA_W-1:0]         rsp_rdata_o
);

    // ****************************************
    // Storage
    // ****************************************

    // Program words, low word plus upper byte
    logic [psta_pkg::PROG_W-1:0]    prog_mem [psta_pkg::PROG_WORDS];
    // Data EEPROM words
    logic [psta_pkg::DATA_W-1:0]    ee_mem   [psta_pkg::EE_WORDS];

    // Answer flops and their next values
    logic                           rsp_valid_q;
    logic                           rsp_valid_d;
    logic [psta_pkg::DATA_W-1:0]    rsp_rdata_q;
    logic [psta_pkg::DATA_W-1:0]    rsp_rdata_d;

    // ****************************************
    // Address decode
    // ****************************************

    // Decode nets
    wire                            is_ee;
    wire                            byte_sel;
    wire [psta_pkg::ROW_W-1:0]      row;
    wire [psta_pkg::PROG_IDX_W-1:0] prog_idx;
    wire [psta_pkg::EE_IDX_W-1:0]   ee_idx;
    wire [psta_pkg::ADDR_W-1:0]     ee_probe;

    // EEPROM window match on the upper address bits
    assign ee_probe = req_addr_i & psta_pkg::EE_MASK;
    assign is_ee    = (ee_probe == psta_pkg::EE_BASE);                    // see R2

    // Bit 0 picks the byte, the rest picks the word
    assign byte_sel = req_addr_i[psta_pkg::SEL_BIT];
    assign row      = req_addr_i[psta_pkg::ADDR_W-1:psta_pkg::ROW_LSB];   // see R5

    // Program index wraps; EEPROM index uses the low row bits
    assign prog_idx = row[psta_pkg::PROG_IDX_W-1:0];
    assign ee_idx   = row[psta_pkg::EE_IDX_W-1:0];

    // ****************************************
    // Operation decode
    // ****************************************

    // Operation strobes
    wire                            is_rd_low;
    wire                            is_wr_low;
    wire                            is_rd_high;
    wire                            is_wr_high;
    wire                            is_read;

    // One strobe per operation code, qualified by valid
    assign is_rd_low  = req_valid_i && (req_op_i == psta_pkg::PSTA_OP_RD_LOW);
    assign is_wr_low  = req_valid_i && (req_op_i == psta_pkg::PSTA_OP_WR_LOW);
    assign is_rd_high = req_valid_i && (req_op_i == psta_pkg::PSTA_OP_RD_HIGH);
    assign is_wr_high = req_valid_i && (req_op_i == psta_pkg::PSTA_OP_WR_HIGH);
    assign is_read    = is_rd_low || is_rd_high;

    // ****************************************
    // Addressed words
    // ****************************************

    // Stored words at the request address
    wire [psta_pkg::PROG_W-1:0]     prog_word;
    wire [psta_pkg::DATA_W-1:0]     ee_word;
    wire [psta_pkg::DATA_W-1:0]     prog_low;
    wire [psta_pkg::DATA_W-1:0]     low_word;
    wire [psta_pkg::BYTE_W-1:0]     high_byte;

    // Both memories are read combinationally
    assign prog_word = prog_mem[prog_idx];
    assign ee_word   = ee_mem[ee_idx];

    // Low space is program bits 15:0 or an EEPROM word
    assign prog_low  = prog_word[psta_pkg::LOW_MSB:psta_pkg::LOW_LSB];    // see R1
    assign low_word  = is_ee ? ee_word : prog_low;                         // see R2

    // High space holds only program bits 23:16
    assign high_byte = prog_word[psta_pkg::HIGH_MSB:psta_pkg::HIGH_LSB];  // see R3

    // ****************************************
    // Read data shaping
    // ****************************************

    // Shaped read words
    wire [psta_pkg::BYTE_W-1:0]     low_lo_byte;
    wire [psta_pkg::BYTE_W-1:0]     low_hi_byte;
    wire [psta_pkg::BYTE_W-1:0]     low_pick;
    wire [psta_pkg::DATA_W-1:0]     rd_low_word;
    wire [psta_pkg::DATA_W-1:0]     rd_low_byte;
    wire [psta_pkg::DATA_W-1:0]     rd_low;
    wire                            phantom_sel;
    wire [psta_pkg::DATA_W-1:0]     rd_high_word;
    wire [psta_pkg::DATA_W-1:0]     rd_high;
    wire [psta_pkg::DATA_W-1:0]     rd_data;

    // Split the low word into its two bytes
    assign low_lo_byte  = low_word[psta_pkg::BYTE_LO_LSB +: psta_pkg::BYTE_W];
    assign low_hi_byte  = low_word[psta_pkg::BYTE_HI_LSB +: psta_pkg::BYTE_W];

    // Low read: whole word, or the selected byte in the low lane
    assign low_pick     = byte_sel ? low_hi_byte : low_lo_byte;            // see R7
    assign rd_low_word  = low_word;                                        // see R6
    assign rd_low_byte  = {psta_pkg::ZERO_BYTE, low_pick};                 // see R7
    assign rd_low       = req_byte_i ? rd_low_byte : rd_low_word;          // see R10

    // High read: upper byte in the low lane, phantom byte always zero
    assign phantom_sel  = req_byte_i && byte_sel;                          // see R9
    assign rd_high_word = {psta_pkg::ZERO_BYTE, high_byte};                // see R8
    assign rd_high      = phantom_sel ? psta_pkg::ZERO_WORD : rd_high_word; // see R9

    // Pick by operation
    assign rd_data      = is_rd_high ? rd_high : rd_low;

    // ****************************************
    // Write data merge
    // ****************************************

    // Merged write words and enables
    wire [psta_pkg::BYTE_W-1:0]     wr_byte;
    wire [psta_pkg::DATA_W-1:0]     wr_low_byte;
    wire [psta_pkg::DATA_W-1:0]     wr_low;
    wire                            ee_wr_en;
    wire                            prog_low_en;
    wire                            wr_high_en;
    wire                            prog_wr_en;
    wire [psta_pkg::PROG_W-1:0]     prog_low_word;
    wire [psta_pkg::PROG_W-1:0]     prog_high_word;
    wire [psta_pkg::PROG_W-1:0]     prog_wr_word;

    // Byte form carries its byte in data bits 7:0
    assign wr_byte        = req_wdata_i[psta_pkg::BYTE_LO_LSB +: psta_pkg::BYTE_W];

    // Byte write keeps the other byte of the low word
    assign wr_low_byte    = byte_sel ? {wr_byte, low_lo_byte} : {low_hi_byte, wr_byte}; // see R10
    assign wr_low         = req_byte_i ? wr_low_byte : req_wdata_i;                     // see R10

    // Low writes go to EEPROM or program bits 15:0
    assign ee_wr_en       = is_wr_low && is_ee;                                         // see R2
    assign prog_low_en    = is_wr_low && !is_ee;                                        // see R1

    // High writes skip the EEPROM window and the phantom byte
    assign wr_high_en     = is_wr_high && !is_ee && !phantom_sel;                       // see R11

    // New program word for either kind of write
    assign prog_low_word  = {high_byte, wr_low};
    assign prog_high_word = {wr_byte, prog_low};                                        // see R3
    assign prog_wr_en     = prog_low_en || wr_high_en;
    assign prog_wr_word   = prog_low_en ? prog_low_word : prog_high_word;

    // ****************************************
    // Memory writes
    // ****************************************

    // EEPROM word write
    always_ff @(posedge clock_i) begin
        if (ee_wr_en) begin
            ee_mem[ee_idx] <= wr_low;
        end
    end

    // Program word write
    always_ff @(posedge clock_i) begin
        if (prog_wr_en) begin
            prog_mem[prog_idx] <= prog_wr_word;
        end
    end

    // ****************************************
    // Answer
    // ****************************************

    // Every request is answered; only reads load new data.
    // Memories are not reset, so a read of an unwritten word
    // answers with unknown data; a read right after a write
    // sees the new word, as memory reads are combinational.
    assign rsp_valid_d = req_valid_i;                                      // see R10
    assign rsp_rdata_d = is_read ? rd_data : rsp_rdata_q;

    // Answer registers
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            rsp_valid_q <= 1'h0;
            rsp_rdata_q <= psta_pkg::ZERO_WORD;
        end else begin
            rsp_valid_q <= rsp_valid_d;
            rsp_rdata_q <= rsp_rdata_d;
        end
    end

    // Outputs straight from the flops
    assign rsp_valid_o = rsp_valid_q;
    assign rsp_rdata_o = rsp_rdata_q;

endmodule : psta_table_access

/* verification/psta_properties.sv */
`timescale 1ns/1ps
module psta_chk (input logic clock_i, reset_n_i, req_valid_i, req_byte_i, input psta_pkg::psta_op_t req_op_i,
    input logic rsp_valid_o, input logic [15:0] req_addr_i, req_wdata_i, rsp_rdata_o);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    wire [2:0]  k = {req_valid_i, req_op_i};
    wire        b = req_byte_i;
    wire [15:0] a = req_addr_i, d = req_wdata_i, q = rsp_rdata_o;
    chk_answer_due: assert property (k[2] |=> rsp_valid_o) else $error("late");
    chk_no_stray: assert property (!k[2] |=> !rsp_valid_o) else $error("stray");
    chk_write_keeps: assert property (k[2] && k[0] |=> $stable(q)) else $error("moved");
    chk_high_zero: assert property (k == 3'h6 && !b |=> q[15:8] == 8'h0) else $error("upper");
    chk_phantom_zero: assert property (k == 3'h6 && b && a[0] |=> q == 16'h0) else $error("phantom");
    chk_low_back: assert property (k == 3'h5 && !b ##1 k == 3'h4 && !b && a == $past(a)
        |=> q == $past(d, 2)) else $error("low");
    chk_byte_back: assert property (k == 3'h5 && b ##1 k == 3'h4 && b && a == $past(a)
        |=> q[7:0] == $past(d[7:0], 2)) else $error("byte");
    chk_high_back: assert property (k == 3'h7 && !b && a[15:9] != 7'h3f ##1 k == 3'h6 && !b && a == $past(a)
        |=> q == {8'h0, $past(d[7:0], 2)}) else $error("high");
endmodule : psta_chk
bind psta_table_access psta_chk chk (.*);

/* verification/psta_core_model.sv */
`timescale 1ns/1ps
// Core side: one request per rising edge, held until the next call
module psta_core_model (input logic clock_i, output logic req_valid_i = 1'h0, req_byte_i = 1'h0,
    output logic [15:0] req_addr_i = 16'h0, req_wdata_i = 16'h0, output psta_pkg::psta_op_t req_op_i);
    task put(logic v, logic [1:0] o, logic b, logic [15:0] a, d);
        @(posedge clock_i);
        {req_valid_i, req_byte_i, req_addr_i, req_wdata_i} <= {v, b, a, d};
        req_op_i <= psta_pkg::psta_op_t'(o);
    endtask : put
endmodule : psta_core_model

/* verification/psta_table_access_tb.sv */
`timescale 1ns/1ps
module psta_table_access_tb;
    logic clock_i = 1'h0, reset_n_i = 1'h0, req_valid_i, req_byte_i, rsp_valid_o;
    psta_pkg::psta_op_t req_op_i;
    logic [15:0] req_addr_i, req_wdata_i, rsp_rdata_o, w, h, r, a;
    logic [3:0] c, st [10] = '{4'h4, 4'h0, 4'h7, 4'h3, 4'h2, 4'hc, 4'h8, 4'hf, 4'hb, 4'ha};
    int n_errors = 0, checks_done = 0, cyc = 0;
    always #2.5 clock_i = ~clock_i;
    always @(posedge clock_i) if (++cyc > 2000) begin n_errors++; complete_run(); end
    psta_core_model core (.*);
    psta_table_access dut (.*);
    function logic [15:0] nx(logic [15:0] s); return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]}; endfunction : nx
    // Step code is op, byte form, byte select
    function logic [15:0] ex(logic [3:0] k);
        return k[3] ? {8'h0, h[7:0] & {8{!(k[1] & k[0])}}} : k[1] ? {8'h0, w[k[0] * 8 +: 8]} : w;
    endfunction : ex
    task chk(string n, logic [15:0] s, e);
        checks_done++;
        if (s !== e) begin n_errors++; $display("BAD %s exp %h seen %h", n, e, s); end
    endtask : chk
    task complete_run;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        r = 16'hafb0;
        repeat (16) @(posedge clock_i);
        #1 chk("reset rdata", rsp_rdata_o, 16'h0);
        chk("reset valid", {15'h0, rsp_valid_o}, 16'h0);
        @(posedge clock_i);
        reset_n_i <= 1'h1;
        for (int i = 0; i < 40; i++) begin
            r = nx(r); w = nx(r); h = nx(w); r = nx(h);
            a = i ? {r[0] ? 7'h3f : r[15:9], r[8:1], 1'h0} : 16'h7ffe;
            for (int s = 0; s < (a[15:9] == 7'h3f ? 5 : 10); s++) begin
                c = st[s];
                core.put(1'h1, c[3:2], c[1], {a[15:1], c[0]}, c[3] ? (c[0] ? ~h : h) : c[1] ? r : w);
                if (s == 2) w[15:8] = r[7:0];
                if (!c[2]) begin
                    core.put(1'h0, c[3:2], c[1], a, a);
                    #1 chk("rdata", rsp_rdata_o, ex(c));
                    chk("valid", {15'h0, rsp_valid_o}, 16'h1);
                end
            end
        end
        complete_run();
    end
endmodule : psta_table_access_tb
